// file: logic/pod_pkg.sv
// Shared constants for the port output disable controller and its timer end.
package pod_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DIV_W  = 7;
  localparam int NPIN   = 6;
  localparam int NPWM   = 10;
  localparam int NXF    = 5;

  localparam logic [7:0] OFS_FAULT = 8'h00;
  localparam logic [7:0] OFS_OSTAT = 8'h04;
  localparam logic [7:0] OFS_ALVL  = 8'h08;
  localparam logic [7:0] OFS_PAIR  = 8'h0C;
  localparam logic [7:0] OFS_SWDIS = 8'h10;
  localparam logic [7:0] OFS_PWMZ  = 8'h14;
  localparam logic [7:0] OFS_ADD   = 8'h18;

  localparam int FLT_MODE_LSB  = 0;
  localparam int FLT_CNT_LSB   = 4;
  localparam int FLT_FLAG_BIT  = 8;
  localparam int OST_FLAG_BIT  = 0;
  localparam int PAIR_MASK_LSB = 3;
  localparam int ADD_CH0_LSB   = 4;

  localparam logic [3:0] MODE_EDGE = 4'h0;
  localparam logic [3:0] MODE_D8   = 4'h1;
  localparam logic [3:0] MODE_D16  = 4'h2;
  localparam logic [3:0] MODE_D128 = 4'h3;
  localparam logic [3:0] MODE_D1   = 4'h4;
  localparam logic [3:0] MODE_D2   = 4'h5;
  localparam logic [3:0] MODE_D4   = 4'h6;

  localparam logic [6:0] DMASK_1   = 7'h00;
  localparam logic [6:0] DMASK_2   = 7'h01;
  localparam logic [6:0] DMASK_4   = 7'h03;
  localparam logic [6:0] DMASK_8   = 7'h07;
  localparam logic [6:0] DMASK_16  = 7'h0F;
  localparam logic [6:0] DMASK_128 = 7'h7F;

  localparam logic [4:0] REDUCED_SAMPLES = 5'h10;
  localparam logic [5:0] ALVL_RST        = 6'h3F;

  // Pin order of the monitored pairs: 3b, 3d, 4a, 4c, 4b, 4d.
  localparam int PIN_3B = 0;
  localparam int PIN_3D = 1;
  localparam int PIN_4A = 2;
  localparam int PIN_4C = 3;
  localparam int PIN_4B = 4;
  localparam int PIN_4D = 5;
endpackage

// file: logic/pod_link_if.sv
// Link between the output disable controller and the timer outputs.
`timescale 1ns/100ps
interface pod_link_if;
  import pod_pkg::*;
  logic              fault_in_pin;
  logic [NPIN-1:0]   motor_pwm_out;
  logic [NPIN-1:0]   motor_pwm_oe;
  logic [NPIN-1:0]   pin_hiz;
  logic              motor_ch0_hiz;
  logic [NPWM-1:0]   pwm_hiz;

  modport ctrl (
    input  fault_in_pin,
    input  motor_pwm_out,
    output pin_hiz,
    output motor_ch0_hiz,
    output pwm_hiz
  );
  modport timer (
    output fault_in_pin,
    output motor_pwm_out,
    output motor_pwm_oe,
    input  pin_hiz,
    input  motor_ch0_hiz,
    input  pwm_hiz
  );
endinterface

// file: logic/pod_timer_end.sv
// Timer side: drives the fault pin and PWM outputs, obeys the disable lines.
`timescale 1ns/100ps
module pod_timer_end (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  pod_link_if.timer                  link,
  input  wire logic [pod_pkg::NPIN-1:0] pwm_level_i,
  input  wire logic                  fault_level_i,
  output logic [pod_pkg::NPIN-1:0]   pwm_oe_o,
  output logic [pod_pkg::NPWM-1:0]   pwm_hiz_o,
  output logic                       motor_ch0_hiz_o
);
  import pod_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] pwm;
    logic            fault;
    logic [NPIN-1:0] oe;
    logic [NPWM-1:0] pwm_hiz;
    logic            ch0_hiz;
  } pod_tmr_state_t;

  pod_tmr_state_t s_q;
  pod_tmr_state_t s_d;

  // Software keeps the pin high and the pairs inactive before clearing flags.
  always_comb begin
    s_d         = s_q;
    s_d.pwm     = pwm_level_i;
    s_d.fault   = fault_level_i;
    s_d.oe      = ~link.pin_hiz;
    s_d.pwm_hiz = link.pwm_hiz;
    s_d.ch0_hiz = link.motor_ch0_hiz;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.fault <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.fault_in_pin  = s_q.fault;
  assign link.motor_pwm_out = s_q.pwm;
  assign link.motor_pwm_oe  = s_q.oe;
  assign pwm_oe_o           = s_q.oe;
  assign pwm_hiz_o          = s_q.pwm_hiz;
  assign motor_ch0_hiz_o    = s_q.ch0_hiz;
endmodule

// file: logic/pod_ctrl.sv
// Port output disable controller: fault pin, short-through and hi-z control.
// Behaviour
// - Mode 0000 takes falling fault pin edges.
// - Modes 1-6 sample at clock /8,/16,/128,/1,/2,/4.
// - Sampled modes need consecutive low samples.
// - Four-bit field selects the low sample count.
// - Software uses only the seven defined codes.
// - Reduced variant: sixteen samples at /8,/16,/128.
// - Selected pin condition sets the fault flag.
// - Fault flag clears by zero write after one read.
// - Pin must be high before clearing sampled fault.
// - Short-through flag only for enabled pairs.
// - Pairs 3b/3d, 4a/4c, 4b/4d gated by enables.
// - Both pins active one cycle sets short-through.
// - Short-through clears after read, pins inactive.
// - Each pair pin has programmable active level.
// - Software disables for six timer pin groups.
// - One hi-z enable per PWM channel 0-9.
// - Faults 0, 9, 13, 14 may disable motor ch3/4.
// - Faults 8, 9 may disable motor ch0.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
module pod_ctrl #(
  parameter bit REDUCED_MODE = 1'b0
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  pod_link_if.ctrl                        link,
  input  wire logic [pod_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [pod_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       we_i,
  input  wire logic                       re_i,
  input  wire logic [pod_pkg::NXF-1:0]    other_fault_flags_i,
  output logic [pod_pkg::DATA_W-1:0]      rdata_o
);
  import pod_pkg::*;

  typedef struct packed {
    logic [3:0]        fault_mode_sel;
    logic [3:0]        fault_sample_count_sel;
    logic              fault_detect_flag;
    logic              fault_armed;
    logic              short_through_flag;
    logic              short_armed;
    logic [NPIN-1:0]   active_level;
    logic [2:0]        pair_hiz_en;
    logic [NPIN-1:0]   portmode_mask_en;
    logic [5:0]        sw_disable;
    logic [NPWM-1:0]   pwm_hiz_en;
    logic [5:0]        add_en;
    logic              sync1;
    logic              sync2;
    logic              prev;
    logic [DIV_W-1:0]  div;
    logic [4:0]        low_cnt;
    logic [DATA_W-1:0] rdata;
    logic [NPIN-1:0]   pin_hiz;
    logic              ch0_hiz;
    logic [NPWM-1:0]   pwm_hiz;
  } pod_ctrl_state_t;

  pod_ctrl_state_t s_q;
  pod_ctrl_state_t s_d;

  logic            sampled;
  logic            mode_ok;
  logic [6:0]      dmask;
  logic [4:0]      need;
  logic            smp_en;
  logic            fault_set;
  logic [NPIN-1:0] act;
  logic [2:0]      pair_hit;
  logic            short_set;
  logic            all_inactive;
  logic            ch34_cond;
  logic [NPWM-1:0] grp;

  // Mode decode; without REDUCED_MODE, prohibited codes detect nothing rather than guess a rate.
  always_comb begin
    sampled = 1'b1;
    mode_ok = 1'b1;
    dmask   = DMASK_1;
    need    = {1'b0, s_q.fault_sample_count_sel} + 5'h01;
    if (REDUCED_MODE) begin
      need = REDUCED_SAMPLES;
      unique case (s_q.fault_mode_sel[1:0])
        2'h0: sampled = 1'b0;
        2'h1: dmask = DMASK_8;
        2'h2: dmask = DMASK_16;
        2'h3: dmask = DMASK_128;
      endcase
    end else begin
      unique case (s_q.fault_mode_sel)
        MODE_EDGE: sampled = 1'b0;
        MODE_D8:   dmask = DMASK_8;
        MODE_D16:  dmask = DMASK_16;
        MODE_D128: dmask = DMASK_128;
        MODE_D1:   dmask = DMASK_1;
        MODE_D2:   dmask = DMASK_2;
        MODE_D4:   dmask = DMASK_4;
        default: begin
          sampled = 1'b0;
          mode_ok = 1'b0;
        end
      endcase
    end
  end

  assign smp_en = sampled && ((s_q.div & dmask) == 7'h00);

  // Short-through: pins compared against their programmed active level.
  always_comb begin
    act = ~(link.motor_pwm_out ^ s_q.active_level);
    for (int k = 0; k < 3; k++) begin
      pair_hit[k] = act[2*k] & act[2*k+1]
                  & (s_q.pair_hiz_en[k] | s_q.portmode_mask_en[2*k]
                     | s_q.portmode_mask_en[2*k+1]);
    end
  end

  assign short_set    = |pair_hit;
  assign all_inactive = ~|act;

  // Disable sources; an enabled pin is never released while any source stays set.
  assign ch34_cond = s_q.sw_disable[0] | s_q.fault_detect_flag | s_q.short_through_flag
                   | (s_q.add_en[0] & other_fault_flags_i[0])
                   | (s_q.add_en[1] & other_fault_flags_i[2])
                   | (s_q.add_en[2] & other_fault_flags_i[3])
                   | (s_q.add_en[3] & other_fault_flags_i[4]);

  // Channel groups 0-1, 2-3, 0-2, 4-6 and 7-9.
  assign grp = {{3{s_q.sw_disable[5]}}, {3{s_q.sw_disable[4]}},
                s_q.sw_disable[2],
                s_q.sw_disable[2] | s_q.sw_disable[3],
                s_q.sw_disable[1] | s_q.sw_disable[3],
                s_q.sw_disable[1] | s_q.sw_disable[3]};

  always_comb begin
    s_d       = s_q;
    fault_set = 1'b0;
    s_d.sync1 = link.fault_in_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.div   = s_q.div + 7'h01;
    s_d.rdata = '0;

    // Fault detection on the synchronised pin.
    if (!sampled) begin
      s_d.low_cnt = '0;
      fault_set   = mode_ok & s_q.prev & ~s_q.sync2;
    end else if (smp_en) begin
      if (!s_q.sync2) begin
        if (s_q.low_cnt < need) begin
          s_d.low_cnt = s_q.low_cnt + 5'h01;
        end
        fault_set = (s_q.low_cnt + 5'h01) >= need;
      end else begin
        s_d.low_cnt = '0;
      end
    end

    // Register reads; reading a set flag arms its clear.
    if (re_i) begin
      unique case (addr_i)
        OFS_FAULT: begin
          s_d.rdata[FLT_MODE_LSB +: 4] = s_q.fault_mode_sel;
          s_d.rdata[FLT_CNT_LSB +: 4]  = s_q.fault_sample_count_sel;
          s_d.rdata[FLT_FLAG_BIT]      = s_q.fault_detect_flag;
          if (s_q.fault_detect_flag) begin
            s_d.fault_armed = 1'b1;
          end
        end
        OFS_OSTAT: begin
          s_d.rdata[OST_FLAG_BIT] = s_q.short_through_flag;
          if (s_q.short_through_flag) begin
            s_d.short_armed = 1'b1;
          end
        end
        OFS_ALVL:  s_d.rdata[NPIN-1:0] = s_q.active_level;
        OFS_PAIR:  s_d.rdata[8:0] = {s_q.portmode_mask_en, s_q.pair_hiz_en};
        OFS_SWDIS: s_d.rdata[5:0] = s_q.sw_disable;
        OFS_PWMZ:  s_d.rdata[NPWM-1:0] = s_q.pwm_hiz_en;
        OFS_ADD:   s_d.rdata[5:0] = s_q.add_en;
        default:   s_d.rdata = '0;
      endcase
    end

    // Register writes; a zero write clears only an armed flag.
    if (we_i) begin
      unique case (addr_i)
        OFS_FAULT: begin
          s_d.fault_mode_sel         = wdata_i[FLT_MODE_LSB +: 4];
          s_d.fault_sample_count_sel = wdata_i[FLT_CNT_LSB +: 4];
          s_d.fault_armed            = 1'b0;
          if (!wdata_i[FLT_FLAG_BIT] && s_q.fault_armed
              && (!sampled || s_q.sync2)) begin
            s_d.fault_detect_flag = 1'b0;
          end
        end
        OFS_OSTAT: begin
          s_d.short_armed = 1'b0;
          if (!wdata_i[OST_FLAG_BIT] && s_q.short_armed && all_inactive) begin
            s_d.short_through_flag = 1'b0;
          end
        end
        OFS_ALVL:  s_d.active_level = wdata_i[NPIN-1:0];
        OFS_PAIR: begin
          s_d.pair_hiz_en      = wdata_i[2:0];
          s_d.portmode_mask_en = wdata_i[PAIR_MASK_LSB +: NPIN];
        end
        OFS_SWDIS: s_d.sw_disable = wdata_i[5:0];
        OFS_PWMZ:  s_d.pwm_hiz_en = wdata_i[NPWM-1:0];
        OFS_ADD:   s_d.add_en = wdata_i[5:0];
        default: begin
        end
      endcase
    end

    // A flag event in the clearing cycle is kept: set wins.
    if (fault_set) begin
      s_d.fault_detect_flag = 1'b1;
    end
    if (short_set) begin
      s_d.short_through_flag = 1'b1;
    end

    // Outputs are registered, so hi-z follows its cause by one cycle.
    for (int i = 0; i < NPIN; i++) begin
      s_d.pin_hiz[i] = ch34_cond
                     & (s_q.pair_hiz_en[i/2] | s_q.portmode_mask_en[i]);
    end
    s_d.ch0_hiz = (s_q.add_en[ADD_CH0_LSB] & other_fault_flags_i[1])
                | (s_q.add_en[ADD_CH0_LSB+1] & other_fault_flags_i[2]);
    s_d.pwm_hiz = grp & s_q.pwm_hiz_en;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q              <= '0;
      s_q.active_level <= ALVL_RST;
      s_q.sync1        <= 1'b1;
      s_q.sync2        <= 1'b1;
      s_q.prev         <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.pin_hiz       = s_q.pin_hiz;
  assign link.motor_ch0_hiz = s_q.ch0_hiz;
  assign link.pwm_hiz       = s_q.pwm_hiz;
  assign rdata_o            = s_q.rdata;
endmodule

// file: verification/pod_link_chk.sv
// Checker on the link and register port of the output disable pair.
`timescale 1ns/100ps
module pod_link_chk (
  input wire logic                       sys_clk_i,
  input wire logic                       rst_i,
  input wire logic [pod_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pod_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       we_i,
  input wire logic                       re_i,
  input wire logic [pod_pkg::DATA_W-1:0] rdata_o,
  input wire logic [pod_pkg::NXF-1:0]    other_fault_flags_i,
  input wire logic                       fault_in_pin,
  input wire logic [pod_pkg::NPIN-1:0]   motor_pwm_out,
  input wire logic [pod_pkg::NPIN-1:0]   motor_pwm_oe,
  input wire logic [pod_pkg::NPIN-1:0]   pin_hiz,
  input wire logic                       motor_ch0_hiz,
  input wire logic [pod_pkg::NPWM-1:0]   pwm_hiz
);
  import pod_pkg::*;
  // Shadows of the control fields, so each check knows what software asked for.
  logic [3:0] mode_q;
  logic [5:0] alvl_q;
  logic [8:0] pen_q;
  logic [9:0] pwmz_q;
  logic [5:0] add_q;
  logic [5:0] act;
  assign act = ~(motor_pwm_out ^ alvl_q);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_EDGE;
      alvl_q <= ALVL_RST;
      pen_q  <= '0;
      pwmz_q <= '0;
      add_q  <= '0;
    end else if (we_i) begin
      if (addr_i == OFS_FAULT) mode_q <= wdata_i[3:0];
      if (addr_i == OFS_ALVL) alvl_q <= wdata_i[5:0];
      if (addr_i == OFS_PAIR) pen_q <= wdata_i[8:0];
      if (addr_i == OFS_PWMZ) pwmz_q <= wdata_i[9:0];
      if (addr_i == OFS_ADD) add_q <= wdata_i[5:0];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_edge;
    mode_q == MODE_EDGE && pen_q[2:0] == 3'h7 && $fell(fault_in_pin);
  endsequence
  sequence s_grp;
    we_i && addr_i == OFS_SWDIS && wdata_i[1] && pwmz_q[1:0] == 2'h3 ##1 !we_i;
  endsequence
  sequence s_off;
    we_i && addr_i == OFS_PWMZ && wdata_i[9:0] == 10'h000 ##1 !we_i;
  endsequence
  reset_quiet_a: assert property ($fell(rst_i) |-> fault_in_pin && !pin_hiz && !pwm_hiz)
    else $error("link not idle after reset");
  oe_follow_a: assert property (!$past(rst_i) |-> motor_pwm_oe == ~$past(pin_hiz))
    else $error("pad enable does not follow hi-z line");
  read_idle_a: assert property (!$past(re_i) |-> rdata_o == '0)
    else $error("read data outside read cycle");
  edge_fault_a: assert property (s_edge |-> ##[3:5] pin_hiz == 6'h3F)
    else $error("falling fault pin did not disable pins");
  for (genvar p = 0; p < 3; p++) begin : g_pair
    short_pair_a: assert property (act[2*p] && act[2*p+1] && pen_q[p]
      |-> ##2 pin_hiz[2*p+:2] == 2'b11)
      else $error("short-through did not disable pair");
  end
  pwm_group_a: assert property (s_grp |-> ##1 pwm_hiz[1:0] == 2'b11)
    else $error("group disable missed pwm 0-1");
  pwm_off_a: assert property (s_off |-> ##1 pwm_hiz == '0)
    else $error("pwm hi-z without channel enable");
  ch0_add_a: assert property (other_fault_flags_i[1] && add_q[ADD_CH0_LSB]
    |-> ##[1:2] motor_ch0_hiz)
    else $error("added fault did not disable motor ch0");
endmodule

// file: verification/tb_pod_ctrl.sv
// Self-checking bench for the output disable controller facing its timer end.
`timescale 1ns/100ps
module tb_pod_ctrl;
  import pod_pkg::*;
  logic              sys_clk_i;
  logic              rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              we_i;
  logic              re_i;
  logic [DATA_W-1:0] rdata_o;
  logic [NXF-1:0]    other_fault_flags_i;
  logic [NPIN-1:0]   lvl;
  logic              flt;
  logic [5:0]        al;
  logic [8:0]        pe;
  logic [5:0]        lv;
  logic [9:0]        pz;
  logic [5:0]        ad;
  logic [3:0]        cs;
  logic [3:0]        md;
  logic [1:0]        ex;
  int                n;
  int                err_count = 0;
  int                tests_run = 0;
  pod_link_if link_if();
  pod_ctrl pod_ctrl_inst (.sys_clk_i, .rst_i, .link(link_if), .addr_i, .wdata_i, .we_i, .re_i,
    .other_fault_flags_i, .rdata_o);
  pod_timer_end pod_timer_end_inst (.sys_clk_i, .rst_i, .link(link_if), .pwm_level_i(lvl),
    .fault_level_i(flt), .pwm_oe_o(), .pwm_hiz_o(), .motor_ch0_hiz_o());
  pod_link_chk pod_link_chk_inst (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
    .other_fault_flags_i, .fault_in_pin(link_if.fault_in_pin),
    .motor_pwm_out(link_if.motor_pwm_out), .motor_pwm_oe(link_if.motor_pwm_oe),
    .pin_hiz(link_if.pin_hiz), .motor_ch0_hiz(link_if.motor_ch0_hiz), .pwm_hiz(link_if.pwm_hiz));
  function automatic int div_of(input logic [3:0] m);
    case (m)
      MODE_D8: return 8;
      MODE_D16: return 16;
      MODE_D128: return 128;
      MODE_D2: return 2;
      MODE_D4: return 4;
      default: return 1;
    endcase
  endfunction
  function automatic logic sflag(input logic [5:0] a, input logic [8:0] e, input logic [5:0] v);
    logic [5:0] act;
    act = ~(v ^ a);
    sflag = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (act[2*p] && act[2*p+1] && (e[p] || e[3+2*p] || e[4+2*p])) sflag = 1'b1;
    end
  endfunction
  function automatic logic [9:0] gmask(input int g);
    case (g)
      1: return 10'h003;
      2: return 10'h00C;
      3: return 10'h007;
      4: return 10'h070;
      5: return 10'h380;
      default: return 10'h000;
    endcase
  endfunction
  function automatic logic [1:0] add_exp(input int k, input logic [5:0] a);
    case (k)
      0: return {1'b0, a[0]};
      1: return {a[4], 1'b0};
      2: return {a[5], a[1]};
      3: return {1'b0, a[2]};
      default: return {1'b0, a[3]};
    endcase
  endfunction
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  // Each strobe is followed by an idle edge, so no signal is driven twice in one step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    cyc(1);
    we_i <= 1'b0;
    cyc(1);
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken inside that cycle.
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    addr_i <= a;
    re_i   <= 1'b1;
    cyc(1);
    re_i <= 1'b0;
    #1;
    chk(rdata_o, e);
    cyc(1);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    cyc(60000);
    err_count++;
    stop_test();
  end
  initial begin
    rst_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    we_i = 1'b0;
    re_i = 1'b0;
    other_fault_flags_i = '0;
    lvl = '0;
    flt = 1'b1;
    void'($urandom(32'h48C0141A));
    cyc(5);
    rst_i <= 1'b0;
    rdc(OFS_FAULT, 16'h0000);
    rdc(OFS_ALVL, 16'h003F);
    wr(8'hF0, 16'hFFFF);
    rdc(8'hF0, 16'h0000);
    wr(OFS_PAIR, 16'h0007);
    flt <= 1'b0;
    cyc(8);
    chk({10'h000, link_if.pin_hiz}, 16'h003F);
    wr(OFS_FAULT, 16'h0000);
    rdc(OFS_FAULT, 16'h0100);
    wr(OFS_FAULT, 16'h0000);
    rdc(OFS_FAULT, 16'h0000);
    flt <= 1'b1;
    cyc(3);
    chk({10'h000, link_if.pin_hiz}, 16'h0000);
    for (int m = 1; m < 7; m++) begin
      md = m[3:0];
      cs = 4'($urandom_range(0, 15));
      n = div_of(md);
      wr(OFS_FAULT, {8'h00, cs, md});
      // A low pulse of cs periods holds one sample too few.
      if (cs != 4'h0) begin
        flt <= 1'b0;
        cyc(int'(cs) * n);
        flt <= 1'b1;
        cyc(2 * n + 4);
      end
      rdc(OFS_FAULT, {8'h00, cs, md});
      flt <= 1'b0;
      cyc((int'(cs) + 1) * n + 8);
      rdc(OFS_FAULT, {8'h01, cs, md});
      wr(OFS_FAULT, {8'h00, cs, md});
      rdc(OFS_FAULT, {8'h01, cs, md});
      flt <= 1'b1;
      cyc(4);
      rdc(OFS_FAULT, {8'h01, cs, md});
      wr(OFS_FAULT, {8'h00, cs, md});
      rdc(OFS_FAULT, {8'h00, cs, md});
    end
    md = 4'($urandom_range(7, 15));
    wr(OFS_FAULT, {12'h000, md});
    flt <= 1'b0;
    cyc(300);
    rdc(OFS_FAULT, {12'h000, md});
    flt <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      al = 6'($urandom);
      pe = 9'($urandom);
      lv = 6'($urandom);
      if (i == 0) begin
        al = 6'h3B;
        pe = 9'h040;
        lv = 6'h08;
      end
      wr(OFS_PAIR, 16'h0000);
      wr(OFS_ALVL, {10'h000, al});
      lvl <= ~al;
      wr(OFS_PAIR, {7'h00, pe});
      lvl <= lv;
      cyc(4);
      rdc(OFS_OSTAT, {15'h0000, sflag(al, pe, lv)});
      wr(OFS_OSTAT, 16'h0000);
      rdc(OFS_OSTAT, {15'h0000, sflag(al, pe, lv)});
      lvl <= ~al;
      cyc(3);
      wr(OFS_OSTAT, 16'h0000);
      rdc(OFS_OSTAT, 16'h0000);
    end
    wr(OFS_PAIR, 16'h0007);
    for (int g = 0; g < 6; g++) begin
      pz = 10'($urandom);
      pz[1:0] = 2'h3;
      wr(OFS_PWMZ, {6'h00, pz});
      wr(OFS_SWDIS, 16'h0001 << g);
      cyc(2);
      chk({6'h00, link_if.pwm_hiz}, {6'h00, pz & gmask(g)});
      chk({10'h000, link_if.pin_hiz}, (g == 0) ? 16'h003F : 16'h0000);
    end
    wr(OFS_PWMZ, 16'h0000);
    wr(OFS_SWDIS, 16'h0000);
    for (int k = 0; k < 10; k++) begin
      ad = 6'($urandom);
      if (k % 5 == 1) ad[4] = 1'b1;
      wr(OFS_ADD, {10'h000, ad});
      other_fault_flags_i <= 5'h01 << (k % 5);
      cyc(3);
      ex = add_exp(k % 5, ad);
      chk({9'h000, link_if.motor_ch0_hiz, link_if.pin_hiz}, {9'h000, ex[1], {6{ex[0]}}});
      other_fault_flags_i <= '0;
      cyc(3);
    end
    stop_test();
  end
endmodule
